// File: rdm_map.svh
`ifndef RDM_MAP_SVH
`define RDM_MAP_SVH

// register byte offsets on the bus
`define RDM_OFF_RX_BASE 8'h00
`define RDM_OFF_TX_BASE 8'h04
`define RDM_OFF_CTRL 8'h08
`define RDM_OFF_POLL 8'h0c
`define RDM_OFF_STAT 8'h10
`define RDM_OFF_CUR 8'h14

// control register fields
`define RDM_CTRL_RX_EN 0
`define RDM_CTRL_SPAN 1

// first receive descriptor word
`define RDM_W0_OWN 31
`define RDM_W0_FL_HI 30
`define RDM_W0_FL_LO 16
`define RDM_W0_ES 15
`define RDM_W0_LE 14
`define RDM_W0_RF 11
`define RDM_W0_FS 9
`define RDM_W0_LS 8
`define RDM_W0_TL 7
`define RDM_W0_CS 6
`define RDM_W0_CRC 1
`define RDM_W0_OVF 0

// second descriptor word
`define RDM_W1_EOR 25
`define RDM_W1_CHAIN 24
`define RDM_W1_B2_HI 21
`define RDM_W1_B2_LO 13
`define RDM_W1_B1_HI 10
`define RDM_W1_B1_LO 2

// descriptor layout and sizes
`define RDM_OFF_W1 32'h0000_0004
`define RDM_OFF_W2 32'h0000_0008
`define RDM_OFF_W3 32'h0000_000c
`define RDM_DESC_BYTES 32'h0000_0010
`define RDM_WORD_BYTES 32'h0000_0004
`define RDM_FL_WORD 15'h0004
`define RDM_RESET_WORD 32'h0000_0000

`endif

// File: rdm_pkg.sv
`default_nettype none
package rdm_pkg;

	typedef enum logic [3:0] {
		RDM_IDLE = 4'h0,
		RDM_RD0 = 4'h1,
		RDM_RD1 = 4'h3,
		RDM_RD2 = 4'h2,
		RDM_RD3 = 4'h6,
		RDM_DATA = 4'h7,
		RDM_WRST = 4'h5,
		RDM_LOOK = 4'h4,
		RDM_DRAIN = 4'hc,
		RDM_STALL = 4'hd
	} rdm_state_t;

	typedef struct packed {
		logic overflow;
		logic crc_err;
		logic late_coll;
		logic too_long;
		logic runt;
	} rdm_rx_flags_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} rdm_mem_req_t;

	typedef struct packed {
		rdm_state_t st;
		logic [31:0] rx_base;
		logic [31:0] tx_base;
		logic rx_en;
		logic span_en;
		logic stalled;
		logic [31:0] cur;
		logic [31:0] link;
		logic [31:0] ptr;
		logic [31:0] buf2;
		logic [8:0] rem1;
		logic [8:0] rem2;
		logic chain;
		logic eor;
		logic [31:0] wd;
		logic pend;
		logic wlast;
		logic [14:0] fl;
		logic first;
		logic cont;
		logic le;
		rdm_rx_flags_t flags;
		logic [7:0] a_addr;
		logic a_wr;
		logic [31:0] hrdata;
	} rdm_top_state_t;

	function automatic logic [31:0] rdm_add(input logic [31:0] a, input logic [31:0] b);
		rdm_add = a + b;
	endfunction : rdm_add

endpackage : rdm_pkg
`default_nettype wire

// File: rdm_next_desc.sv
`timescale 1ns/1ps
`default_nettype none
`include "rdm_map.svh"
module rdm_next_desc
	import rdm_pkg::*;
(
	input wire logic [31:0] cur,
	input wire logic [31:0] base,
	input wire logic chain,
	input wire logic eor,
	input wire logic [31:0] link,
	output logic [31:0] next
);
	always_comb
	begin
		if (chain)
			next = link;
		else if (eor)
			next = base;
		else
			next = rdm_add(cur, `RDM_DESC_BYTES);
	end
endmodule : rdm_next_desc
`default_nettype wire

// File: rdm_rx_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "rdm_map.svh"
module rdm_rx_status
	import rdm_pkg::*;
(
	input wire logic first,
	input wire logic last,
	input wire logic le,
	input wire logic [14:0] fl,
	input wire rdm_rx_flags_t flags,
	output logic [31:0] word
);
	always_comb
	begin
		word = `RDM_RESET_WORD;
		word[`RDM_W0_OWN] = 1'b0;
		word[`RDM_W0_FS] = first;
		word[`RDM_W0_LS] = last;
		// length, error bits only carry meaning on the closing descriptor
		if (last)
		begin
			word[`RDM_W0_FL_HI:`RDM_W0_FL_LO] = fl;
			word[`RDM_W0_LE] = le;
			word[`RDM_W0_OVF] = flags.overflow;
			word[`RDM_W0_CRC] = flags.crc_err;
			word[`RDM_W0_CS] = flags.late_coll;
			word[`RDM_W0_TL] = flags.too_long;
			word[`RDM_W0_RF] = flags.runt;
			word[`RDM_W0_ES] = flags.overflow | flags.crc_err | flags.late_coll |
				flags.too_long | flags.runt | le;
		end
	end
endmodule : rdm_rx_status
`default_nettype wire

// File: rdm_top.sv
// What this block does
// - separate receive and transmit lists, each base held in its own register
// - chained flag in word one makes word three the next descriptor address
// - unchained descriptors hold two buffers and follow each other in memory
// - end-of-ring flag in unchained mode wraps to the list base
// - a buffer never holds data of two frames
// - status goes only into the descriptor, never the buffer
// - frames may span descriptors; spanning can be switched off
// - ownership bit 31 set means the device may fill the buffers
// - device clears ownership at frame end or when buffers fill
// - word zero bits 30:16 hold the frame byte count with CRC
// - length field valid only with last set and length error clear
// - error summary is the OR of the six error bits
// - overrun with next descriptor not owned sets length error and truncates
// - summary and length error valid only on the last descriptor
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rdm_map.svh"
module rdm_top
	import rdm_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output rdm_mem_req_t mem_o,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	input wire logic rx_valid,
	input wire logic [31:0] rx_data,
	input wire logic rx_last,
	input wire logic [2:0] rx_nbytes,
	input wire rdm_rx_flags_t rx_flags,
	output logic rx_ready,
	output logic [31:0] tx_list_base
);

	////////////////////////////////////////////////////////////////////////////////
	rdm_top_state_t q;
	rdm_top_state_t d;
	logic [31:0] next_desc;
	logic [31:0] status_word;
	logic status_last;
	logic room;
	logic wr_phase;
	logic [14:0] nb;

	rdm_next_desc u_next (
		.cur(q.cur),
		.base(q.rx_base),
		.chain(q.chain),
		.eor(q.eor),
		.link(q.link),
		.next(next_desc)
	);

	assign status_last = ~q.cont;

	rdm_rx_status u_status (
		.first(q.first),
		.last(status_last),
		.le(q.le),
		.fl(q.fl),
		.flags(q.flags),
		.word(status_word)
	);

	////////////////////////////////////////////////////////////////////////////////
	// zero-wait slave; size is ignored since only whole words are mapped
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.hrdata;
	assign tx_list_base = q.tx_base;
	assign room = (q.rem1 != 9'h000) || (q.rem2 != 9'h000);
	assign wr_phase = q.a_wr;
	assign nb = rx_last ? {12'h000, rx_nbytes} : `RDM_FL_WORD;

	// data is only accepted into an empty holding word or while discarding
	assign rx_ready = ((q.st == RDM_DATA) && !q.pend) || (q.st == RDM_DRAIN);

	always_comb
	begin
		mem_o = '0;
		case (q.st)
			RDM_RD0:
			begin
				mem_o.req = 1'b1;
				mem_o.addr = q.cur;
			end
			RDM_RD1:
			begin
				mem_o.req = 1'b1;
				mem_o.addr = rdm_add(q.cur, `RDM_OFF_W1);
			end
			RDM_RD2:
			begin
				mem_o.req = 1'b1;
				mem_o.addr = rdm_add(q.cur, `RDM_OFF_W2);
			end
			RDM_RD3:
			begin
				mem_o.req = 1'b1;
				mem_o.addr = rdm_add(q.cur, `RDM_OFF_W3);
			end
			RDM_LOOK:
			begin
				mem_o.req = 1'b1;
				mem_o.addr = next_desc;
			end
			RDM_DATA:
			begin
				mem_o.req = q.pend && room;
				mem_o.we = 1'b1;
				mem_o.addr = q.ptr;
				mem_o.wdata = q.wd;
			end
			RDM_WRST:
			begin
				// status and cleared ownership land in one word write
				mem_o.req = 1'b1;
				mem_o.we = 1'b1;
				mem_o.addr = q.cur;
				mem_o.wdata = status_word;
			end
			default:
			begin
				mem_o = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		d = q;

		// bus address phase, read data registered ahead of the data phase
		d.a_wr = 1'b0;
		if (hsel && htrans[1] && hready)
		begin
			d.a_addr = haddr[7:0];
			d.a_wr = hwrite;
			case (haddr[7:0])
				`RDM_OFF_RX_BASE: d.hrdata = q.rx_base;
				`RDM_OFF_TX_BASE: d.hrdata = q.tx_base;
				`RDM_OFF_CTRL: d.hrdata = {30'h0000_0000, q.span_en, q.rx_en};
				`RDM_OFF_STAT: d.hrdata = {27'h000_0000, q.stalled, q.st};
				`RDM_OFF_CUR: d.hrdata = q.cur;
				default: d.hrdata = `RDM_RESET_WORD;
			endcase
		end

		// bus data phase writes
		if (wr_phase)
		begin
			case (q.a_addr)
				`RDM_OFF_RX_BASE: d.rx_base = hwdata;
				`RDM_OFF_TX_BASE: d.tx_base = hwdata;
				`RDM_OFF_CTRL:
				begin
					d.rx_en = hwdata[`RDM_CTRL_RX_EN];
					d.span_en = hwdata[`RDM_CTRL_SPAN];
					// enabling restarts the walk from the list base
					if (hwdata[`RDM_CTRL_RX_EN] && !q.rx_en)
						d.cur = q.rx_base;
				end
				`RDM_OFF_POLL:
				begin
					if (q.st == RDM_STALL)
					begin
						d.st = RDM_RD0;
						d.stalled = 1'b0;
					end
				end
				default:
				begin
					d.a_wr = 1'b0;
				end
			endcase
		end

		// receive descriptor engine
		case (q.st)
			RDM_IDLE:
			begin
				// a new frame always starts in a fresh descriptor
				if (q.rx_en && rx_valid)
					d.st = RDM_RD0;
			end
			RDM_RD0:
			begin
				if (mem_ack)
				begin
					if (mem_rdata[`RDM_W0_OWN])
						d.st = RDM_RD1;
					else
					begin
						d.st = RDM_STALL;
						d.stalled = 1'b1;
					end
				end
			end
			RDM_RD1:
			begin
				if (mem_ack)
				begin
					d.chain = mem_rdata[`RDM_W1_CHAIN];
					d.eor = mem_rdata[`RDM_W1_EOR];
					d.rem1 = mem_rdata[`RDM_W1_B1_HI:`RDM_W1_B1_LO];
					// chained descriptors carry a link, not a second buffer
					d.rem2 = mem_rdata[`RDM_W1_CHAIN] ? 9'h000 :
						mem_rdata[`RDM_W1_B2_HI:`RDM_W1_B2_LO];
					d.st = RDM_RD2;
				end
			end
			RDM_RD2:
			begin
				if (mem_ack)
				begin
					d.ptr = mem_rdata;
					d.st = RDM_RD3;
				end
			end
			RDM_RD3:
			begin
				if (mem_ack)
				begin
					d.buf2 = mem_rdata;
					d.link = mem_rdata;
					if (q.rem1 == 9'h000)
						d.ptr = mem_rdata;
					d.st = RDM_DATA;
				end
			end
			RDM_DATA:
			begin
				if (!q.pend)
				begin
					if (rx_valid)
					begin
						d.pend = 1'b1;
						d.wd = rx_data;
						d.wlast = rx_last;
						d.fl = q.fl + nb;
						if (rx_last)
							d.flags = rx_flags;
					end
				end
				else if (!room)
				begin
					if (q.span_en)
						d.st = RDM_LOOK;
					else
					begin
						d.le = 1'b1;
						d.pend = 1'b0;
						d.cont = 1'b0;
						d.st = q.wlast ? RDM_WRST : RDM_DRAIN;
					end
				end
				else if (mem_ack)
				begin
					d.pend = 1'b0;
					if (q.rem1 != 9'h000)
					begin
						d.rem1 = q.rem1 - 9'h001;
						d.ptr = (q.rem1 == 9'h001) ? q.buf2 : rdm_add(q.ptr, `RDM_WORD_BYTES);
					end
					else
					begin
						d.rem2 = q.rem2 - 9'h001;
						d.ptr = rdm_add(q.ptr, `RDM_WORD_BYTES);
					end
					if (q.wlast)
					begin
						d.cont = 1'b0;
						d.st = RDM_WRST;
					end
				end
			end
			RDM_LOOK:
			begin
				if (mem_ack)
				begin
					if (mem_rdata[`RDM_W0_OWN])
					begin
						// buffers full, frame goes on in the next descriptor
						d.cont = 1'b1;
						d.st = RDM_WRST;
					end
					else
					begin
						d.le = 1'b1;
						d.pend = 1'b0;
						d.cont = 1'b0;
						d.st = q.wlast ? RDM_WRST : RDM_DRAIN;
					end
				end
			end
			RDM_DRAIN:
			begin
				// truncated tail is discarded but still counted in the length
				if (rx_valid)
				begin
					d.fl = q.fl + nb;
					if (rx_last)
					begin
						d.flags = rx_flags;
						d.st = RDM_WRST;
					end
				end
			end
			RDM_WRST:
			begin
				if (mem_ack)
				begin
					d.cur = next_desc;
					if (q.cont)
					begin
						d.first = 1'b0;
						d.cont = 1'b0;
						d.st = RDM_RD1;
					end
					else
					begin
						d.first = 1'b1;
						d.le = 1'b0;
						d.fl = 15'h0000;
						d.flags = '0;
						d.st = RDM_IDLE;
					end
				end
			end
			RDM_STALL:
			begin
				// left only by a poll write; the flag must drop with it or it sticks
				d.stalled = (d.st == RDM_STALL);
			end
			default:
			begin
				d.st = RDM_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			q <= '0;
			q.first <= 1'b1;
		end
		else if (ce)
		begin
			q <= d;
		end
	end

endmodule : rdm_top
`default_nettype wire

// File: rdm_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rdm_sva
	import rdm_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire rdm_mem_req_t mem_o,
	input wire logic mem_ack,
	input wire logic rx_valid,
	input wire logic rx_last,
	input wire logic [2:0] rx_nbytes,
	input wire logic rx_ready,
	input wire logic [31:0] tx_list_base
);
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
////////////////////////////////////////////////////////////////
// descriptors sit below 0x1000 and buffers above it, so a write there is a status write
logic stw;
logic [14:0] cnt_q;
logic [14:0] fl_q;
assign stw = mem_o.req && mem_o.we && mem_o.addr < 32'h0000_1000;
always_ff @(posedge hclk or negedge hresetn)
	if (!hresetn)
	begin
		cnt_q <= 15'h0000;
		fl_q <= 15'h0000;
	end
	else if (rx_valid && rx_ready && ce)
	begin
		cnt_q <= rx_last ? 15'h0000 : cnt_q + 15'h0004;
		if (rx_last)
			fl_q <= cnt_q + {12'h000, rx_nbytes};
	end
////////////////////////////////////////////////////////////////
property p_bus;
	hreadyout && !hresp;
endproperty
a_bus: assert property (p_bus) else $error("slave not ready or not okay");
property p_txb;
	hsel && htrans[1] && hready && ce && hwrite && haddr[7:0] == 8'h04 ##1 ce
	|=> tx_list_base == $past(hwdata);
endproperty
a_txb: assert property (p_txb) else $error("transmit base not written");
property p_frz;
	!ce |=> $stable(tx_list_base);
endproperty
a_frz: assert property (p_frz) else $error("state moved while frozen");
property p_hold;
	mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o.addr) && $stable(mem_o.wdata)
	&& $stable(mem_o.we);
endproperty
a_hold: assert property (p_hold) else $error("memory request changed early");
property p_own;
	stw |-> !mem_o.wdata[31];
endproperty
a_own: assert property (p_own) else $error("status kept ownership");
property p_es;
	stw |-> mem_o.wdata[15] == |{mem_o.wdata[14], mem_o.wdata[11], mem_o.wdata[7:6],
	mem_o.wdata[1:0]};
endproperty
a_es: assert property (p_es) else $error("summary flag wrong");
property p_mid;
	stw && !mem_o.wdata[8] |-> mem_o.wdata[30:14] == 17'h00000;
endproperty
a_mid: assert property (p_mid) else $error("non-last status carries length");
property p_fl;
	stw && mem_o.wdata[8] && !mem_o.wdata[14] |-> mem_o.wdata[30:16] == fl_q;
endproperty
a_fl: assert property (p_fl) else $error("frame length wrong");
property p_done;
	rx_valid && rx_ready && rx_last && ce |-> ##[1:40] stw;
endproperty
a_done: assert property (p_done) else $error("no status after frame end");
c_last: cover property (stw && mem_o.wdata[8] && mem_o.wdata[15]);
c_trunc: cover property (stw && mem_o.wdata[14]);
c_span: cover property (stw && !mem_o.wdata[8]);
endmodule : rdm_sva
bind rdm_top rdm_sva chk_u (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hreadyout, .hresp, .mem_o, .mem_ack, .rx_valid, .rx_last, .rx_nbytes, .rx_ready,
	.tx_list_base);
`default_nettype wire

// File: rdm_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module rdm_mem_model
	import rdm_pkg::*;
(
	input wire logic hclk,
	input wire rdm_mem_req_t mem_o,
	input wire logic [1:0] lat,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
logic [31:0] mem [0:2047];
logic [1:0] n;
initial
begin
	foreach (mem[i])
		mem[i] = 32'h0000_0000;
	mem_ack = 1'b0;
	mem_rdata = 32'h0000_0000;
	n = 2'h0;
end
// read data toggles outside the ack cycle so a stale word never looks valid
always @(posedge hclk)
begin
	mem_ack <= 1'b0;
	mem_rdata <= ~mem_rdata;
	if (mem_o.req && !mem_ack)
	begin
		if (n < lat)
			n <= n + 2'h1;
		else
		begin
			n <= 2'h0;
			mem_ack <= 1'b1;
			if (mem_o.we)
				mem[mem_o.addr[12:2]] <= mem_o.wdata;
			else
				mem_rdata <= mem[mem_o.addr[12:2]];
		end
	end
end
endmodule : rdm_mem_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
	import rdm_pkg::*;
;
logic hclk = 1'b0;
logic hresetn = 1'b0;
logic ce = 1'b1;
logic hsel = 1'b0;
logic hwrite = 1'b0;
logic rx_valid = 1'b0;
logic rx_last = 1'b0;
logic [31:0] haddr = 32'h0;
logic [31:0] hwdata = 32'h0;
logic [31:0] rx_data = 32'h0;
logic [1:0] htrans = 2'h0;
logic [1:0] lat = 2'h0;
logic [2:0] rx_nbytes = 3'h0;
rdm_rx_flags_t rx_flags = 5'h00;
logic hreadyout, hresp, hready, mem_ack, rx_ready;
logic [31:0] hrdata, mem_rdata, tx_list_base;
rdm_mem_req_t mem_o;
int n_fail = 0;
int check_count = 0;
logic [31:0] rs = 32'h0000_004c;
logic [31:0] w [0:3];
logic [63:0] exp_q [$];
logic [63:0] e;
assign hready = hreadyout;
rdm_top dut_u (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
	.hready, .hreadyout, .hresp, .hrdata, .mem_o, .mem_ack, .mem_rdata, .rx_valid, .rx_data,
	.rx_last, .rx_nbytes, .rx_flags, .rx_ready, .tx_list_base);
rdm_mem_model mem_u (.hclk, .mem_o, .lat, .mem_ack, .mem_rdata);
initial
begin
	forever
		#2.5 hclk = ~hclk;
end
////////////////////////////////////////////////////////////////
task automatic print_verdict;
	$display("checks %0d mismatches %0d", check_count, n_fail);
	if (n_fail == 0 && check_count > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask : print_verdict
task automatic chk(input logic [31:0] s, input logic [31:0] x);
	check_count++;
	if (s !== x)
	begin
		n_fail++;
		$display("[ERR] %0t seen %h expected %h", $time, s, x);
	end
endtask : chk
task automatic hang;
	n_fail++;
	$display("[ERR] %0t timeout seen %h expected %h", $time, 1'b0, 1'b1);
	print_verdict();
endtask : hang
function automatic logic [31:0] xs();
	rs = rs ^ (rs << 13);
	rs = rs ^ (rs >> 17);
	rs = rs ^ (rs << 5);
	return rs;
endfunction : xs
function automatic logic [31:0] sw(input logic f, input logic l, input logic le,
	input logic [14:0] n, input rdm_rx_flags_t g);
	logic es;
	es = l & ((|g) | le);
	return {1'b0, l ? n : 15'h0000, es, l & le, 2'h0, l & g.runt, 1'b0, f, l, l & g.too_long,
		l & g.late_coll, 4'h0, l & g.crc_err, l & g.overflow};
endfunction : sw
// single-word AHB transfer; the master waits on hready, never on a fixed count
task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
	input logic [31:0] x);
	int k;
	hsel <= 1'b1;
	htrans <= 2'h2;
	hwrite <= wr;
	haddr <= {24'h000000, a};
	for (k = 0; k < 50; k++)
	begin
		@(posedge hclk);
		if (hready)
			break;
	end
	if (k == 50)
		hang();
	htrans <= 2'h0;
	hsel <= 1'b0;
	hwdata <= d;
	for (k = 0; k < 50; k++)
	begin
		@(posedge hclk);
		if (hready)
			break;
	end
	if (k == 50)
		hang();
	if (!wr)
		chk(hrdata, x);
endtask : bus
task automatic dsc(input logic [31:0] a, input logic [31:0] w1, input logic [31:0] b,
	input logic [31:0] w3);
	mem_u.mem[a[12:2] + 11'h1] = w1;
	mem_u.mem[a[12:2] + 11'h2] = b;
	mem_u.mem[a[12:2] + 11'h3] = w3;
	mem_u.mem[a[12:2]] = 32'h8000_0000;
endtask : dsc
// ready is combinational, so it is sampled away from the edge that moves it
task automatic rxw(input logic [31:0] d, input logic l, input logic [2:0] nb,
	input rdm_rx_flags_t f);
	int k;
	logic r;
	rx_valid <= 1'b1;
	rx_data <= d;
	rx_last <= l;
	rx_nbytes <= nb;
	rx_flags <= f;
	for (k = 0; k < 200; k++)
	begin
		@(negedge hclk);
		r = rx_ready;
		@(posedge hclk);
		if (r)
			break;
	end
	if (k == 200)
		hang();
endtask : rxw
task automatic frm(input int n, input logic [2:0] nb, input rdm_rx_flags_t f);
	int k;
	w[0] = xs();
	lat <= w[0][1:0];
	for (k = 0; k < n; k++)
	begin
		w[k] = xs();
		rxw(w[k], k == n - 1, nb, f);
	end
	rx_valid <= 1'b0;
	for (k = 0; k < 400 && exp_q.size() > 0; k++)
		@(posedge hclk);
	if (k == 400)
		hang();
	$display("frame of %0d words done", n);
endtask : frm
////////////////////////////////////////////////////////////////
always @(posedge hclk)
	if (mem_o.req && mem_o.we && mem_ack && mem_o.addr < 32'h0000_1000)
	begin
		e = exp_q.size() > 0 ? exp_q.pop_front() : 64'h0;
		chk(mem_o.addr, e[63:32]);
		chk(mem_o.wdata, e[31:0]);
	end
initial
begin
	int i;
	logic [31:0] a;
	repeat (3) @(posedge hclk);
	hresetn <= 1'b1;
	@(posedge hclk);
	bus(1'b1, 8'h04, 32'h0000_0a40, 32'h0);
	bus(1'b0, 8'h04, 32'h0, 32'h0000_0a40);
	chk(tx_list_base, 32'h0000_0a40);
	bus(1'b0, 8'h00, 32'h0, 32'h0);
	bus(1'b1, 8'h20, 32'hffff_ffff, 32'h0);
	bus(1'b0, 8'h20, 32'h0, 32'h0);
	ce <= 1'b0;
	@(posedge hclk);
	ce <= 1'b1;
	$display("register test done");
	dsc(32'h0000_0100, 32'h0000_0010, 32'h0000_1000, 32'h0);
	dsc(32'h0000_0110, 32'h0200_0010, 32'h0000_1100, 32'h0);
	bus(1'b1, 8'h00, 32'h0000_0100, 32'h0);
	bus(1'b1, 8'h08, 32'h0000_0001, 32'h0);
	exp_q.push_back({32'h0000_0100, sw(1'b1, 1'b1, 1'b0, 15'h0008, 5'h00)});
	frm(2, 3'h4, 5'h00);
	chk(mem_u.mem[11'h400], w[0]);
	chk(mem_u.mem[11'h402], 32'h0);
	bus(1'b0, 8'h14, 32'h0, 32'h0000_0110);
	exp_q.push_back({32'h0000_0110, sw(1'b1, 1'b1, 1'b0, 15'h0005, 5'h08)});
	frm(2, 3'h1, 5'h08);
	dsc(32'h0000_0100, 32'h0000_0010, 32'h0000_1000, 32'h0);
	exp_q.push_back({32'h0000_0100, sw(1'b1, 1'b1, 1'b0, 15'h0004, 5'h00)});
	frm(1, 3'h4, 5'h00);
	bus(1'b1, 8'h08, 32'h0, 32'h0);
	bus(1'b1, 8'h00, 32'h0000_0200, 32'h0);
	for (i = 0; i < 5; i++)
	begin
		a = i[0] ? 32'h0000_0300 : 32'h0000_0200;
		dsc(a, 32'h0100_0010, a + 32'h0000_1000, a ^ 32'h0000_0100);
		if (i == 0)
			bus(1'b1, 8'h08, 32'h0000_0001, 32'h0);
		exp_q.push_back({a, sw(1'b1, 1'b1, 1'b0, 15'h0004, 5'h10 >> i)});
		frm(1, 3'h4, 5'h10 >> i);
	end
	bus(1'b1, 8'h08, 32'h0, 32'h0);
	bus(1'b1, 8'h00, 32'h0000_0400, 32'h0);
	dsc(32'h0000_0400, 32'h0000_0004, 32'h0000_1400, 32'h0);
	bus(1'b1, 8'h08, 32'h0000_0003, 32'h0);
	exp_q.push_back({32'h0000_0400, sw(1'b1, 1'b1, 1'b1, 15'h000c, 5'h00)});
	frm(3, 3'h4, 5'h00);
	chk(mem_u.mem[11'h501], 32'h0);
	for (i = 0; i < 2; i++)
	begin
		a = i[0] ? 32'h0000_0600 : 32'h0000_0500;
		bus(1'b1, 8'h08, 32'h0, 32'h0);
		bus(1'b1, 8'h00, a, 32'h0);
		dsc(a, 32'h0000_0004, a + 32'h0000_1000, 32'h0);
		dsc(a + 32'h0000_0010, 32'h0000_0010, a + 32'h0000_1100, 32'h0);
		bus(1'b1, 8'h08, i[0] ? 32'h0000_0001 : 32'h0000_0003, 32'h0);
		if (i == 0)
		begin
			exp_q.push_back({a, sw(1'b1, 1'b0, 1'b0, 15'h0000, 5'h00)});
			exp_q.push_back({a + 32'h10, sw(1'b0, 1'b1, 1'b0, 15'h0008, 5'h00)});
		end
		else
			exp_q.push_back({a, sw(1'b1, 1'b1, 1'b1, 15'h0008, 5'h00)});
		frm(2, 3'h4, 5'h00);
	end
	// descriptor handed back to the host: the engine must park until polled
	mem_u.mem[11'h184] = 32'h0;
	rx_valid <= 1'b1;
	repeat (20) @(posedge hclk);
	bus(1'b0, 8'h10, 32'h0, 32'h0000_001d);
	mem_u.mem[11'h184] = 32'h8000_0000;
	exp_q.push_back({32'h0000_0610, sw(1'b1, 1'b1, 1'b0, 15'h0004, 5'h00)});
	bus(1'b1, 8'h0c, 32'h0, 32'h0);
	frm(1, 3'h4, 5'h00);
	bus(1'b0, 8'h10, 32'h0, 32'h0);
	bus(1'b0, 8'h14, 32'h0, 32'h0000_0620);
	$display("stall test done");
	print_verdict();
end
endmodule : tb
`default_nettype wire
